// file: src/fcd_pkg.sv
// shared constants for the floppy command decoder
package fcd_pkg;
  localparam logic [2:0] OFS_STATUS_A   = 3'h0;
  localparam logic [2:0] OFS_STATUS_B   = 3'h1;
  localparam logic [2:0] OFS_DIG_OUT    = 3'h2;
  localparam logic [2:0] OFS_TAPE       = 3'h3;
  localparam logic [2:0] OFS_MAIN_STAT  = 3'h4;
  localparam logic [2:0] OFS_FIFO       = 3'h5;
  localparam logic [2:0] OFS_DIG_IN     = 3'h7;
  localparam logic [4:0] OPC_READ       = 5'h06;
  localparam logic [4:0] OPC_READ_DEL   = 5'h0C;
  localparam logic [4:0] OPC_READ_TRACK = 5'h02;
  localparam logic [4:0] OPC_READ_ID    = 5'h0A;
  localparam logic [4:0] OPC_VERIFY     = 5'h16;
  localparam logic [4:0] OPC_WRITE      = 5'h05;
  localparam logic [4:0] OPC_WRITE_DEL  = 5'h09;
  localparam logic [4:0] OPC_FORMAT     = 5'h0D;
  localparam logic [7:0] OPC_VERSION    = 8'h10;
  localparam logic [7:0] OPC_RECAL      = 8'h07;
  localparam logic [7:0] OPC_SENSE_INT  = 8'h08;
  localparam logic [7:0] OPC_SPECIFY    = 8'h03;
  localparam logic [7:0] OPC_SEEK       = 8'h0F;
  localparam logic [7:0] OPC_CONFIGURE  = 8'h13;
  localparam logic [7:0] OPC_DUMPREG    = 8'h0E;
  localparam logic [7:0] OPC_PERP       = 8'h12;
  localparam logic [6:0] OPC_LOCK       = 7'h14;
  localparam logic [7:0] OPC_SENSE_DRV  = 8'h04;
  localparam logic [7:0] STATUS_INVALID  = 8'h80;
  localparam logic [7:0] STATUS_SEEK_END = 8'h20;
  localparam logic [7:0] STATUS_ABNORMAL = 8'h40;
  localparam int         MAX_BYTES      = 10;
  // step pulse width and spacing, given in ns and rounded up to whole clocks
  localparam int         STEP_NS        = 1000;
  localparam int         CLK_NS         = 10;
  localparam int         STEP_CYCLES    = (STEP_NS + CLK_NS - 1) / CLK_NS;
  // arbitrary version value
  localparam logic [7:0] VERSION_BYTE   = 8'h5A;
  localparam logic [7:0] PRECOMP_TRACK_RESET  = 8'h00;
  localparam logic [3:0] FIFO_THRESHOLD_RESET = 4'h0;
  typedef enum logic [2:0] {FCD_IDLE, FCD_CMD, FCD_EXEC, FCD_RESULT} fcd_phase_t;
endpackage

// file: src/fcd_toggle.sv
// toggle flip-flop flipping on every rising edge of a sampled line
`timescale 1ns/100ps
`default_nettype none
module fcd_toggle (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic line_in,
  output var  logic toggle_out
);
  logic line_prev;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      // start from the pin level so an idle high line gives no false edge
      line_prev  <= line_in;
      toggle_out <= 1'b0;
    end else begin
      line_prev <= line_in;
      if (line_in && !line_prev) begin
        toggle_out <= !toggle_out;
      end
    end
  end
endmodule
`default_nettype wire

// file: src/fcd_decoder.sv
// floppy command decoder with status register front end
// Summary of operation
// - unknown opcode does nothing, returns single result byte 80H.
// - recalibrate steps outward to track zero, raises interrupt, no result.
// - seek byte two holds head at bit 2, drive at bits 1..0.
// - seek steps head to the new cylinder, returns no result bytes.
// - dump command loads cylinders and internal parameters as result bytes.
// - dump lock byte: lock, zero, perpendicular enables, gap, write gate.
// - verify takes count flag in bit 7, transfers no data.
// - status A bit 7 shows interrupt output in both modes.
// - enhanced mode status A shows drive pins with listed polarities.
// - compact mode status A shows drive pins with listed polarities.
// - enhanced status B bits 4 and 3 toggle on write/read data rises.
// - enhanced status B bit 5 drive select bit, bit 2 inverted write enable.
// - enhanced status B bits 1,0 are inverted motor enables B, A.
// - compact status B bit 7 second drive, bits 6,5 drive selects.
// - registers decode by offset from the base for reads and writes.
// - commands pass through command, execution, then result phases; unknown opcodes skip execution, seeks skip result.
// - with lock set, fifo settings and precomp track survive software reset.
`timescale 1ns/100ps
`default_nettype none
module fcd_decoder
  import fcd_pkg::*;
#(
  parameter int STEP_LEN = STEP_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [2:0] addr_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output var  logic [7:0] rdata_out,
  input  wire logic       compact_mode_in,
  input  wire logic       track_zero_in,
  input  wire logic       index_pulse_in,
  input  wire logic       write_protect_in,
  input  wire logic       second_drive_present_in,
  input  wire logic       read_data_line_in,
  input  wire logic       write_data_out_in,
  input  wire logic       write_enable_out_in,
  input  wire logic       dma_request_in,
  input  wire logic       disk_change_in,
  output var  logic       step_pulse_out,
  output var  logic       step_dir_out,
  output var  logic       head_side_out,
  output var  logic       drive_select_a_out,
  output var  logic       drive_select_b_out,
  output var  logic       motor_on_a_out,
  output var  logic       motor_on_b_out,
  output var  logic       interrupt_out,
  output var  logic [7:0] digital_output_out,
  output var  logic [7:0] transfer_rate_out,
  output var  logic [7:0] rate_config_out,
  output var  logic       execute_out,
  output var  logic [7:0] exec_command_out,
  input  wire logic       exec_done_in
);
  if (STEP_LEN < 1 || STEP_LEN > 32767) begin : g_bad_step
    $error("STEP_LEN must be between 1 and 32767");
  end

  fcd_phase_t  phase;
  logic [7:0]  cmd [MAX_BYTES];
  logic [3:0]  cmd_cnt;
  logic [3:0]  cmd_len;
  logic [7:0]  res [MAX_BYTES];
  logic [3:0]  res_cnt;
  logic [3:0]  res_len;
  logic [7:0]  present_cylinder [4];
  logic [7:0]  target;
  logic [1:0]  sel_drive;
  logic [7:0]  status_zero;
  logic [7:0]  spec_rate;
  logic [7:0]  spec_load;
  logic [7:0]  sector_limit;
  logic        lock_flag;
  logic [3:0]  perp_en;
  logic        gap_flag;
  logic        write_gate_flag;
  logic        implied_seek;
  logic        fifo_enable_flag;
  logic        poll_off;
  logic [3:0]  fifo_threshold;
  logic [7:0]  precomp_start_track;
  logic [7:0]  tape_assign;
  logic [15:0] step_timer;
  logic        step_latch;
  logic        wd_toggle;
  logic        rd_toggle;
  logic [7:0]  first;
  logic [4:0]  low_op;
  logic        fifo_wr;
  logic        fifo_rd;
  logic        soft_reset;
  logic [3:0]  next_len;
  logic        move_done;

  assign fifo_wr    = wr_in && addr_in == OFS_FIFO;
  assign fifo_rd    = rd_in && addr_in == OFS_FIFO;
  assign soft_reset = wr_in && addr_in == OFS_MAIN_STAT && wdata_in[7];
  assign first      = cmd[0];
  // flags sit in the top three bits of sector commands
  // split opcode field
  assign low_op     = first[4:0];
  // recalibrate ends on the track zero pin, the seeks on the cylinder count
  assign move_done  = step_timer == 16'd0 && (first == OPC_RECAL ? !track_zero_in
                      : present_cylinder[sel_drive] == target);

  // command length from the first byte, zero marks an unknown opcode
  always_comb begin
    next_len = 4'd0;
    unique case (1'b1)
      low_op == OPC_READ, low_op == OPC_READ_DEL, low_op == OPC_WRITE,
      low_op == OPC_WRITE_DEL, low_op == OPC_VERIFY:          next_len = 4'd9;
      first[7:5] == 3'b000 && low_op == OPC_READ_TRACK[4:0]:   next_len = 4'd9;
      first[7] == 1'b0 && first[5:0] == {1'b0, OPC_READ_ID}:   next_len = 4'd2;
      first[7] == 1'b0 && first[5:0] == {1'b0, OPC_FORMAT}:    next_len = 4'd6;
      first == OPC_RECAL, first == OPC_SENSE_DRV:              next_len = 4'd2;
      first == OPC_SEEK:                                       next_len = 4'd3;
      first == OPC_SPECIFY:                                    next_len = 4'd3;
      first == OPC_CONFIGURE:                                  next_len = 4'd4;
      first == OPC_PERP:                                       next_len = 4'd2;
      first[6:0] == OPC_LOCK, first == OPC_VERSION:            next_len = 4'd1;
      first == OPC_SENSE_INT, first == OPC_DUMPREG:            next_len = 4'd1;
      first[7:6] == 2'b10 && first[4:0] == 5'h0F:              next_len = 4'd3;
      default:                                                 next_len = 4'd0;
    endcase
  end

  // three phase command sequencer
  // command execute result
  always_ff @(posedge clk_in) begin
    if (reset_in || soft_reset) begin
      phase       <= FCD_IDLE;
      cmd_cnt     <= 4'd0;
      cmd_len     <= 4'd0;
      res_cnt     <= 4'd0;
      res_len     <= 4'd0;
      execute_out <= 1'b0;
      exec_command_out <= 8'h00;
      target      <= 8'h00;
      sel_drive   <= 2'd0;
      for (int i = 0; i < MAX_BYTES; i++) begin
        res[i] <= 8'h00;
        cmd[i] <= 8'h00;
      end
    end else begin
      execute_out <= 1'b0;
      unique case (phase)
        FCD_IDLE: begin
          if (fifo_wr) begin
            cmd[0]  <= wdata_in;
            cmd_cnt <= 4'd1;
            phase   <= FCD_CMD;
          end
        end
        FCD_CMD: begin
          if (cmd_cnt == 4'd1) begin
            cmd_len <= next_len;
          end
          if (cmd_cnt == 4'd1 && next_len == 4'd0) begin
            res[0]  <= STATUS_INVALID;
            res_len <= 4'd1;
            res_cnt <= 4'd0;
            phase   <= FCD_RESULT;
          end else if (cmd_cnt != 4'd1 && cmd_cnt == cmd_len ||
                       cmd_cnt == 4'd1 && next_len == 4'd1) begin
            phase            <= FCD_EXEC;
            exec_command_out <= first;
            execute_out      <= 1'b1;
            sel_drive        <= cmd[1][1:0];
            target           <= (first == OPC_RECAL) ? 8'h00 : cmd[2];
          end else if (fifo_wr) begin
            cmd[cmd_cnt] <= wdata_in;
            cmd_cnt      <= cmd_cnt + 4'd1;
          end
        end
        FCD_EXEC: begin
          res_cnt <= 4'd0;
          unique case (1'b1)
            first == OPC_RECAL, first == OPC_SEEK,
            first[7:6] == 2'b10 && first[4:0] == 5'h0F: begin
              if (move_done) begin
                phase <= FCD_IDLE;
              end
            end
            first == OPC_SPECIFY, first == OPC_CONFIGURE, first == OPC_PERP: begin
              phase <= FCD_IDLE;
            end
            first == OPC_SENSE_INT: begin
              res[0]  <= status_zero;
              res[1]  <= present_cylinder[sel_drive];
              res_len <= 4'd2;
              phase   <= FCD_RESULT;
            end
            first == OPC_DUMPREG: begin
              for (int d = 0; d < 4; d++) res[d] <= present_cylinder[d];
              res[4]  <= spec_rate;
              res[5]  <= spec_load;
              res[6]  <= sector_limit;
              res[7]  <= {lock_flag, 1'b0, perp_en, gap_flag, write_gate_flag};
              res[8]  <= {1'b0, implied_seek, fifo_enable_flag, poll_off,
                          fifo_threshold};
              res[9]  <= precomp_start_track;
              res_len <= 4'd10;
              phase   <= FCD_RESULT;
            end
            first == OPC_VERSION: begin
              res[0]  <= VERSION_BYTE;
              res_len <= 4'd1;
              phase   <= FCD_RESULT;
            end
            first[6:0] == OPC_LOCK: begin
              res[0]  <= {3'b000, first[7], 4'h0};
              res_len <= 4'd1;
              phase   <= FCD_RESULT;
            end
            first == OPC_SENSE_DRV: begin
              res[0]  <= {1'b0, !write_protect_in, 1'b1, !track_zero_in, 1'b1,
                          cmd[1][2:0]};
              res_len <= 4'd1;
              phase   <= FCD_RESULT;
            end
            default: begin
              if (exec_done_in || low_op == OPC_VERIFY) begin
                res[0]  <= {6'b000000, cmd[1][1:0]};
                res[1]  <= 8'h00;
                res[2]  <= 8'h00;
                res[3]  <= cmd[2];
                res[4]  <= cmd[3];
                res[5]  <= cmd[4];
                res[6]  <= cmd[5];
                res_len <= 4'd7;
                phase   <= FCD_RESULT;
              end
            end
          endcase
        end
        FCD_RESULT: begin
          if (fifo_rd) begin
            if (res_cnt + 4'd1 >= res_len) begin
              phase <= FCD_IDLE;
            end
            res_cnt <= res_cnt + 4'd1;
          end
        end
      endcase
    end
  end

  // head stepping toward the target cylinder
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      step_timer     <= 16'd0;
      step_pulse_out <= 1'b0;
      step_dir_out   <= 1'b0;
      step_latch     <= 1'b0;
      for (int d = 0; d < 4; d++) present_cylinder[d] <= 8'h00;
    end else begin
      // a status A read clears the latch, a step in the same cycle wins
      if (rd_in && addr_in == OFS_STATUS_A) step_latch <= 1'b0;
      if (step_timer != 16'd0) begin
        step_timer <= step_timer - 16'd1;
        if (step_timer == 16'(STEP_LEN)) step_pulse_out <= 1'b0;
      end else if (phase == FCD_EXEC &&
                   (first == OPC_RECAL || first == OPC_SEEK ||
                    first[7:6] == 2'b10 && first[4:0] == 5'h0F)) begin
        if (first == OPC_RECAL && !track_zero_in) begin
          present_cylinder[sel_drive] <= 8'h00;
        end else if (first == OPC_RECAL || present_cylinder[sel_drive] != target) begin
          // recalibrate steps outward blind, the count is unknown until track zero
          step_dir_out   <= first != OPC_RECAL && target > present_cylinder[sel_drive];
          step_pulse_out <= 1'b1;
          step_latch     <= 1'b1;
          step_timer     <= 16'(2 * STEP_LEN);
          if (first != OPC_RECAL && target > present_cylinder[sel_drive]) begin
            present_cylinder[sel_drive] <= present_cylinder[sel_drive] + 8'd1;
          end else if (first != OPC_RECAL) begin
            present_cylinder[sel_drive] <= present_cylinder[sel_drive] - 8'd1;
          end
        end
      end
    end
  end

  // completion interrupt and its status byte
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      interrupt_out <= 1'b0;
      status_zero   <= STATUS_INVALID;
    end else if (phase == FCD_EXEC && move_done &&
                 (first == OPC_RECAL || first == OPC_SEEK)) begin
      interrupt_out <= 1'b1;
      status_zero   <= STATUS_SEEK_END | {6'b000000, sel_drive};
    end else if (phase == FCD_EXEC && first == OPC_SENSE_INT) begin
      interrupt_out <= 1'b0;
      status_zero   <= STATUS_INVALID;
    end
  end

  // parameters held by specify, configure, perpendicular and lock
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      spec_rate <= 8'h00;
      spec_load <= 8'h00;
      sector_limit <= 8'h00;
      lock_flag <= 1'b0;
      perp_en   <= 4'h0;
      gap_flag  <= 1'b0;
      write_gate_flag <= 1'b0;
      implied_seek    <= 1'b0;
      poll_off        <= 1'b0;
      fifo_enable_flag    <= 1'b0;
      fifo_threshold      <= FIFO_THRESHOLD_RESET;
      precomp_start_track <= PRECOMP_TRACK_RESET;
    end else if (soft_reset && !lock_flag) begin
      fifo_enable_flag    <= 1'b0;
      fifo_threshold      <= FIFO_THRESHOLD_RESET;
      precomp_start_track <= PRECOMP_TRACK_RESET;
    end else if (phase == FCD_EXEC && cmd_cnt == cmd_len) begin
      if (first == OPC_SPECIFY) begin
        spec_rate <= cmd[1];
        spec_load <= cmd[2];
      end
      if (first == OPC_CONFIGURE) begin
        implied_seek        <= cmd[2][6];
        fifo_enable_flag    <= cmd[2][5];
        poll_off            <= cmd[2][4];
        fifo_threshold      <= cmd[2][3:0];
        precomp_start_track <= cmd[3];
      end
      if (first == OPC_PERP) begin
        if (cmd[1][7]) perp_en <= cmd[1][5:2];
        gap_flag        <= cmd[1][1];
        write_gate_flag <= cmd[1][0];
      end
      if (first[6:0] == OPC_LOCK) lock_flag <= first[7];
      if (next_len == 4'd9) sector_limit <= cmd[6];
    end
  end

  // plain write registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      digital_output_out <= 8'h00;
      transfer_rate_out  <= 8'h00;
      rate_config_out    <= 8'h00;
      tape_assign        <= 8'h00;
    end else if (wr_in) begin
      unique case (addr_in)
        OFS_DIG_OUT:   digital_output_out <= wdata_in;
        OFS_TAPE:      tape_assign        <= {6'b000000, wdata_in[1:0]};
        OFS_MAIN_STAT: transfer_rate_out  <= {1'b0, wdata_in[6:0]};
        OFS_DIG_IN:    rate_config_out    <= wdata_in;
        default: ;
      endcase
    end
  end

  // drive selects and motors follow the digital output register, head side follows bit 2 of command byte two
  always_comb begin
    drive_select_a_out = digital_output_out[1:0] == 2'd0;
    drive_select_b_out = digital_output_out[1:0] == 2'd1;
    motor_on_a_out     = digital_output_out[4];
    motor_on_b_out     = digital_output_out[5];
    head_side_out      = cmd[1][2];
  end

  fcd_toggle u_wd_toggle (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .line_in    (write_data_out_in),
    .toggle_out (wd_toggle)
  );
  fcd_toggle u_rd_toggle (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .line_in    (read_data_line_in),
    .toggle_out (rd_toggle)
  );

  // read mux, registered so data come from flip-flops
  // offset decode
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        OFS_STATUS_A: rdata_out <= compact_mode_in ?
          {interrupt_out, dma_request_in, step_latch, !track_zero_in,
           head_side_out, !index_pulse_in, !write_protect_in, !step_dir_out} :
          {interrupt_out, second_drive_present_in, !step_pulse_out,
           track_zero_in, !head_side_out, index_pulse_in, write_protect_in,
           step_dir_out};
        OFS_STATUS_B: rdata_out <= compact_mode_in ?
          {second_drive_present_in, drive_select_b_out, drive_select_a_out,
           wd_toggle, rd_toggle, !write_enable_out_in, 2'b11} :
          {2'b11, digital_output_out[0], wd_toggle, rd_toggle,
           !write_enable_out_in, !motor_on_b_out, !motor_on_a_out};
        OFS_TAPE:      rdata_out <= tape_assign;
        OFS_MAIN_STAT: rdata_out <= {phase != FCD_EXEC, phase == FCD_RESULT,
                                     phase == FCD_EXEC, phase != FCD_IDLE, 4'h0};
        OFS_FIFO:      rdata_out <= (phase == FCD_RESULT) ? res[res_cnt] : 8'h00;
        OFS_DIG_IN:    rdata_out <= {!disk_change_in, 7'h00};
        default:       rdata_out <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: test/fcd_props.sv
// checker bound to the decoder's ports
`timescale 1ns/100ps
`default_nettype none
module fcd_props
  import fcd_pkg::*;
#(
  parameter int STEP_LEN = STEP_CYCLES
) (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic [2:0] addr_in,
  input wire logic       rd_in,
  input wire logic       wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic       compact_mode_in,
  input wire logic       track_zero_in,
  input wire logic       index_pulse_in,
  input wire logic       write_protect_in,
  input wire logic       second_drive_present_in,
  input wire logic       write_enable_out_in,
  input wire logic       dma_request_in,
  input wire logic       step_pulse_out,
  input wire logic       step_dir_out,
  input wire logic       drive_select_a_out,
  input wire logic       drive_select_b_out,
  input wire logic       motor_on_a_out,
  input wire logic       motor_on_b_out,
  input wire logic       interrupt_out,
  input wire logic [7:0] digital_output_out,
  input wire logic       execute_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  logic sa;
  logic sb;
  int   hi_len;
  assign sa = rd_in && addr_in == OFS_STATUS_A;
  assign sb = rd_in && addr_in == OFS_STATUS_B;
  // a counter, since the pulse width is a parameter and not a fixed repeat
  always_ff @(posedge clk_in) hi_len <= (reset_in || !step_pulse_out) ? 0 : hi_len + 1;
  property p_sa_int;
    sa |=> rdata_out[7] == $past(interrupt_out);
  endproperty
  a_sa_int: assert property (p_sa_int) else $error("status a irq bit wrong");
  property p_sa_enh;
    sa && !compact_mode_in |=> {rdata_out[6], rdata_out[4], rdata_out[2:0]} ==
      {$past(second_drive_present_in), $past(track_zero_in), $past(index_pulse_in),
       $past(write_protect_in), $past(step_dir_out)};
  endproperty
  a_sa_enh: assert property (p_sa_enh) else $error("status a enhanced wrong");
  property p_sa_cmp;
    sa && compact_mode_in |=> {rdata_out[6], rdata_out[4], rdata_out[2:0]} ==
      {$past(dma_request_in), ~$past(track_zero_in), ~$past(index_pulse_in),
       ~$past(write_protect_in), ~$past(step_dir_out)};
  endproperty
  a_sa_cmp: assert property (p_sa_cmp) else $error("status a compact wrong");
  property p_sb_enh;
    sb && !compact_mode_in |=> {rdata_out[5], rdata_out[2:0]} == {$past(digital_output_out[0]),
      ~$past(write_enable_out_in), ~$past(motor_on_b_out), ~$past(motor_on_a_out)};
  endproperty
  a_sb_enh: assert property (p_sb_enh) else $error("status b enhanced wrong");
  property p_sb_cmp;
    sb && compact_mode_in |=> rdata_out[7:5] == {$past(second_drive_present_in),
      $past(drive_select_b_out), $past(drive_select_a_out)};
  endproperty
  a_sb_cmp: assert property (p_sb_cmp) else $error("status b compact wrong");
  property p_do_wr;
    wr_in && addr_in == OFS_DIG_OUT |=> digital_output_out == $past(wdata_in);
  endproperty
  a_do_wr: assert property (p_do_wr) else $error("output register not written");
  property p_step;
    // the pulse drops on the edge after the timer reaches STEP_LEN, one clock extra
    $fell(step_pulse_out) |-> hi_len == STEP_LEN + 1;
  endproperty
  a_step: assert property (p_step) else $error("step pulse width wrong");
  property p_exec;
    execute_out |=> !execute_out;
  endproperty
  a_exec: assert property (p_exec) else $error("execute pulse too long");
endmodule
bind fcd_decoder fcd_props #(.STEP_LEN(STEP_LEN)) u_props (.*);
`default_nettype wire

// file: test/fcd_host_model.sv
// host processor model for the decoder's register port
`timescale 1ns/100ps
`default_nettype none
module fcd_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output var  logic [2:0] addr_out,
  output var  logic       rd_out,
  output var  logic       wr_out,
  output var  logic [7:0] wdata_out
);
  initial begin
    addr_out = 3'h6;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end
  // one strobe cycle, then idle cycles so requests stay at least two apart
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    // a released bus shows the inverse of its last value
    wdata_out = ~d;
    @(negedge clk_in);
    q = rdata_in;
  endtask
endmodule
`default_nettype wire

// file: test/fcd_decoder_bench.sv
// self-checking bench for the floppy command decoder
`timescale 1ns/100ps
`default_nettype none
module fcd_decoder_bench
  import fcd_pkg::*;
;
  logic       clk_in = 1'b0, reset_in = 1'b1, compact_mode_in = 1'b0, exec_done_in = 1'b0;
  logic       track_zero_in = 1'b1, index_pulse_in = 1'b0, write_protect_in = 1'b1;
  logic       second_drive_present_in = 1'b0, read_data_line_in = 1'b0, disk_change_in = 1'b0;
  logic       write_data_out_in = 1'b0, write_enable_out_in = 1'b1, dma_request_in = 1'b0;
  logic       rd_in, wr_in, step_pulse_out, step_dir_out, head_side_out, interrupt_out;
  logic       drive_select_a_out, drive_select_b_out, motor_on_a_out, motor_on_b_out;
  logic       execute_out, step_q, exec_seen, dir_seen;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata_out, digital_output_out, transfer_rate_out, rate_config_out;
  logic [7:0] exec_command_out, rb, dummy;
  int         num_errors = 0, cmp_count = 0, step_cnt = 0;
  fcd_decoder #(.STEP_LEN(2)) u_dut (.*);
  fcd_host_model u_host (
    .clk_in    (clk_in),
    .rdata_in  (rdata_out),
    .addr_out  (addr_in),
    .rd_out    (rd_in),
    .wr_out    (wr_in),
    .wdata_out (wdata_in)
  );
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    step_q <= step_pulse_out;
    if (step_pulse_out && !step_q) step_cnt <= step_cnt + 1;
    if (step_pulse_out) dir_seen <= step_dir_out;
    if (execute_out) exec_seen <= 1'b1;
  end
  task automatic end_sim();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic fail();
    num_errors++;
    end_sim();
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d, dummy);
  endtask
  task automatic wf(input logic [7:0] d);
    wr(OFS_FIFO, d);
  endtask
  task automatic rr(input logic [2:0] a);
    u_host.acc(1'b0, a, 8'h00, rb);
  endtask
  task automatic wait_res();
    for (int i = 0; i < 100; i++) begin
      rr(OFS_MAIN_STAT);
      if (rb[6] === 1'b1) return;
    end
    fail();
  endtask
  task automatic t_regs();
    wr(OFS_DIG_OUT, 8'h15);
    wr(3'h6, 8'hFF);
    chk(digital_output_out, 8'h15);
    wr(3'h7, 8'h02);
    chk(rate_config_out, 8'h02);
    wr(OFS_MAIN_STAT, 8'h01);
    chk(transfer_rate_out, 8'h01);
    wr(OFS_TAPE, 8'h02);
    rr(OFS_TAPE);
    chk(rb & 8'h03, 8'h02);
  endtask
  task automatic t_invalid(input logic [7:0] op);
    wf(op);
    wait_res();
    rr(OFS_FIFO);
    chk(rb, STATUS_INVALID);
    rr(OFS_MAIN_STAT);
    chk({7'h00, rb[6]}, 8'h00);
  endtask
  task automatic t_move(input logic [7:0] op, input logic [7:0] ncn, input int tz);
    int base;
    base = step_cnt;
    wf(op);
    // head 0, drive 0, upper bits zero
    wf(8'h00);
    if (op == OPC_SEEK) wf(ncn);
    for (int i = 0; i < 3000 && interrupt_out !== 1'b1; i++) begin
      @(negedge clk_in);
      if (step_cnt - base >= tz) track_zero_in = 1'b0;
    end
    track_zero_in = 1'b1;
    if (interrupt_out !== 1'b1) fail();
    chk({7'h00, dir_seen}, {7'h00, op == OPC_SEEK});
    if (op == OPC_SEEK) chk(8'(step_cnt - base), ncn);
    else chk(8'(step_cnt - base), 8'(tz));
    rr(OFS_MAIN_STAT);
    chk({7'h00, rb[6]}, 8'h00);
    wf(OPC_SENSE_INT);
    wait_res();
    rr(OFS_FIFO);
    chk(rb, STATUS_SEEK_END);
    rr(OFS_FIFO);
    chk(rb, ncn);
    chk({7'h00, interrupt_out}, 8'h00);
  endtask
  task automatic t_dump();
    logic [7:0] d[10];
    wf(OPC_SPECIFY);
    wf(8'hA5);
    wf(8'h07);
    repeat (4) @(negedge clk_in);
    wf(OPC_PERP);
    wf(8'hBF);
    repeat (4) @(negedge clk_in);
    wf(OPC_DUMPREG);
    wait_res();
    foreach (d[i]) begin
      rr(OFS_FIFO);
      d[i] = rb;
    end
    chk(d[0], 8'h03);
    chk(d[4], 8'hA5);
    chk(d[5], 8'h07);
    chk(d[7], 8'h3F);
  endtask
  task automatic t_verify();
    logic [7:0] vb[9];
    // count flag in bit 7 of byte two, sector count last
    vb = '{8'h56, 8'h80, 8'h01, 8'h00, 8'h02, 8'h02, 8'h09, 8'h1B, 8'h04};
    exec_seen = 1'b0;
    foreach (vb[i]) wf(vb[i]);
    for (int i = 0; i < 50 && exec_seen !== 1'b1; i++) @(negedge clk_in);
    chk({7'h00, exec_seen}, 8'h01);
    chk(exec_command_out, vb[0]);
    exec_done_in = 1'b1;
    @(negedge clk_in);
    exec_done_in = 1'b0;
    wait_res();
    repeat (7) rr(OFS_FIFO);
    rr(OFS_MAIN_STAT);
    chk({7'h00, rb[6]}, 8'h00);
  endtask
  task automatic t_status(input logic cm, input logic [3:0] p);
    compact_mode_in = cm;
    {track_zero_in, index_pulse_in, write_protect_in, second_drive_present_in} = p;
    {dma_request_in, write_enable_out_in} = p[1:0];
    rr(OFS_STATUS_A);
    if (cm) chk(rb & 8'hD6, {1'b0, p[1], 1'b0, ~p[3], 1'b0, ~p[2], ~p[1], 1'b0});
    else chk(rb & 8'hD6, {1'b0, p[0], 1'b0, p[3], 1'b0, p[2], p[1], 1'b0});
    rr(OFS_STATUS_B);
    if (cm) chk(rb & 8'hE0, {p[0], 7'h40});
    else chk(rb & 8'hE4, {3'b111, 2'b00, ~p[0], 2'b00});
    if (!cm) chk(rb & 8'h03, 8'h02);
  endtask
  task automatic t_toggle();
    logic [7:0] r0;
    compact_mode_in = 1'b0;
    rr(OFS_STATUS_B);
    r0 = rb;
    for (int i = 0; i < 2; i++) begin
      {write_data_out_in, read_data_line_in} = i[0] ? 2'b10 : 2'b01;
      repeat (4) @(negedge clk_in);
      {write_data_out_in, read_data_line_in} = 2'b00;
      rr(OFS_STATUS_B);
      chk(rb & 8'h18, {3'b000, r0[4] ^ i[0], ~r0[3], 3'b000});
    end
  endtask
  initial begin
    repeat (8) @(negedge clk_in);
    reset_in = 1'b0;
    t_regs();
    t_invalid(8'h00);
    t_invalid(8'h1F);
    t_move(OPC_RECAL, 8'h00, 2);
    t_move(OPC_SEEK, 8'h03, 1000);
    t_dump();
    t_verify();
    for (int m = 0; m < 2; m++) begin
      t_status(m[0], 4'b1010);
      t_status(m[0], 4'b0101);
    end
    t_toggle();
    end_sim();
  end
endmodule
`default_nettype wire
